/* src/stat_pkg.sv */
/*
 Shared constants for the port statistics counter block.
 Assumes a three-port switch core and the byte-wide indirect register port.
*/
package stat_pkg;
    localparam int PORTS = 3;
    localparam int PER_PORT = 32;
    localparam int ENTRIES = 96;
    localparam int DROPS = 6;
    localparam int LEN_W = 11;
    localparam int CNT_W = 30;
    localparam int DROP_W = 16;
    localparam int IDX_W = 7;
    localparam int CLASH_W = 4;
    // Register map of the indirect port
    localparam logic [7:0] REG_CTRL = 8'h79;
    localparam logic [7:0] REG_TRIG = 8'h7A;
    localparam logic [7:0] REG_DATA3 = 8'h80;
    localparam logic [7:0] REG_DATA2 = 8'h81;
    localparam logic [7:0] REG_DATA1 = 8'h82;
    localparam logic [7:0] REG_DATA0 = 8'h83;
    localparam logic [5:0] SEL_COUNTERS = 6'h07;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // Indirect address map
    localparam logic [9:0] PORT_SPAN = 10'h020;
    localparam logic [9:0] PORT_END = 10'h060;
    localparam logic [9:0] DROP_BASE = 10'h100;
    localparam logic [9:0] DROP_END = 10'h106;
    localparam int OVF_BIT = 31;
    localparam int VALID_BIT = 30;
    // Frame length limits
    localparam logic [10:0] LEN_MIN = 11'h040;
    localparam logic [10:0] LEN_BIN_B = 11'h07F;
    localparam logic [10:0] LEN_BIN_C = 11'h0FF;
    localparam logic [10:0] LEN_BIN_D = 11'h1FF;
    localparam logic [10:0] LEN_BIN_E = 11'h3FF;
    localparam logic [10:0] LEN_MAX_STD = 11'h5F2;
    localparam logic [10:0] LEN_MAX_LONG = 11'h600;
    // Per-port counter indices
    localparam int IX_RX_LO_OCT = 0;
    localparam int IX_RX_HI_OCT = 1;
    localparam int IX_RX_SHORT_GOOD = 2;
    localparam int IX_RX_SHORT_BAD = 3;
    localparam int IX_RX_LONG_GOOD = 4;
    localparam int IX_RX_LONG_BAD = 5;
    localparam int IX_RX_BAD_SYM = 6;
    localparam int IX_RX_CRC_FAIL = 7;
    localparam int IX_RX_MISALIGN = 8;
    localparam int IX_RX_MAC_CTRL = 9;
    localparam int IX_RX_FLOW_STOP = 10;
    localparam int IX_RX_ALL_DEST = 11;
    localparam int IX_RX_GROUP_DEST = 12;
    localparam int IX_RX_SINGLE_DEST = 13;
    localparam int IX_RX_BIN_MIN = 14;
    localparam int IX_TX_LO_OCT = 20;
    localparam int IX_TX_HI_OCT = 21;
    localparam int IX_TX_LATE_CLASH = 22;
    localparam int IX_TX_FLOW_STOP = 23;
    localparam int IX_TX_ALL_DEST = 24;
    localparam int IX_TX_GROUP_DEST = 25;
    localparam int IX_TX_SINGLE_DEST = 26;
    localparam int IX_TX_POSTPONED = 27;
    localparam int IX_TX_ALL_CLASH = 28;
    localparam int IX_TX_ABANDONED = 29;
    localparam int IX_TX_ONE_CLASH = 30;
    localparam int IX_TX_MANY_CLASH = 31;
    typedef logic [LEN_W-1:0] len_type;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FETCH = 2'b01
    } fetch_state_type;
endpackage : stat_pkg

/* src/stat_bank.sv */
/*
 Counter bank: one 30-bit count and a sticky wrap flag per entry.
 Assumes one read per cycle at most; the read clears the entry.
*/
`timescale 1ns/1ns
module stat_bank (
    // Clock, reset and enable
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_ce,
    // Increments, one amount per entry
    input wire stat_pkg::len_type [stat_pkg::ENTRIES-1:0] i_add,
    // Clearing read
    input wire logic i_rd_en,
    input wire logic [stat_pkg::IDX_W-1:0] i_rd_idx,
    output logic [stat_pkg::CNT_W:0] o_rd_word
);
    import stat_pkg::*;

    logic [ENTRIES-1:0][CNT_W-1:0] cnt_q, cnt_d;
    logic [ENTRIES-1:0] ovf_q, ovf_d;
    logic [CNT_W:0] rd_q, rd_d;
    logic [CNT_W:0] sum;

    always_comb begin
        sum = '0;
        cnt_d = cnt_q;
        ovf_d = ovf_q;
        rd_d = rd_q;
        if (i_rd_en) begin
            rd_d = {ovf_q[i_rd_idx], cnt_q[i_rd_idx]};
        end
        for (int i = 0; i < ENTRIES; i++) begin
            sum = {1'b0, cnt_q[i]} + (CNT_W+1)'(i_add[i]);
            if (i_rd_en && i_rd_idx == IDX_W'(i)) begin
                // Read clears, a same-cycle event survives
                cnt_d[i] = CNT_W'(i_add[i]);
                ovf_d[i] = 1'b0;
            end else begin
                cnt_d[i] = sum[CNT_W-1:0];
                ovf_d[i] = ovf_q[i] | sum[CNT_W];
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            cnt_q <= '0;
            ovf_q <= '0;
            rd_q <= '0;
        end else if (i_ce) begin
            cnt_q <= cnt_d;
            ovf_q <= ovf_d;
            rd_q <= rd_d;
        end
    end

    assign o_rd_word = rd_q;

    chk_read_clears: assert property (
        @(posedge i_mclk) disable iff (!i_nrst || !i_ce)
        i_rd_en && i_add[i_rd_idx] == '0 |=> cnt_q[$past(i_rd_idx)] == '0)
        else $error("Counter not cleared by read");

    chk_ovf_sticky: assert property (
        @(posedge i_mclk) disable iff (!i_nrst || !i_ce)
        ovf_q[0] && !(i_rd_en && i_rd_idx == '0) |=> ovf_q[0])
        else $error("Overflow flag lost before read");
endmodule : stat_bank

/* src/port_stats.sv */
/*
 Port statistics counters with indirect read access.
 Assumes the MACs report one summary per finished frame, synchronous to
 i_mclk, and the management port uses single-cycle byte accesses.
*/
`timescale 1ns/1ns
module port_stats (
    // Clock, reset, enable
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_ce,
    // Management byte port
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    // Configuration
    input wire logic i_long_max,
    // Receive frame summaries
    input wire logic [stat_pkg::PORTS-1:0] i_rx_valid,
    input wire stat_pkg::len_type [stat_pkg::PORTS-1:0] i_rx_len,
    input wire logic [stat_pkg::PORTS-1:0] i_rx_hi_prio,
    input wire logic [stat_pkg::PORTS-1:0] i_rx_bad_crc,
    input wire logic [stat_pkg::PORTS-1:0] i_rx_odd_bits,
    input wire logic [stat_pkg::PORTS-1:0] i_rx_bad_symbol,
    input wire logic [stat_pkg::PORTS-1:0] i_rx_mac_ctrl,
    input wire logic [stat_pkg::PORTS-1:0] i_rx_pause_fmt,
    input wire logic [stat_pkg::PORTS-1:0] i_rx_bcast,
    input wire logic [stat_pkg::PORTS-1:0] i_rx_mcast,
    // Transmit frame summaries
    input wire logic [stat_pkg::PORTS-1:0] i_tx_valid,
    input wire stat_pkg::len_type [stat_pkg::PORTS-1:0] i_tx_len,
    input wire logic [stat_pkg::PORTS-1:0] i_tx_ok,
    input wire logic [stat_pkg::PORTS-1:0] i_tx_hi_prio,
    input wire logic [stat_pkg::PORTS-1:0] i_tx_pause,
    input wire logic [stat_pkg::PORTS-1:0] i_tx_bcast,
    input wire logic [stat_pkg::PORTS-1:0] i_tx_mcast,
    input wire logic [stat_pkg::PORTS-1:0] i_tx_postponed,
    input wire logic [stat_pkg::PORTS-1:0] i_tx_late_clash,
    input wire logic [stat_pkg::PORTS-1:0][stat_pkg::CLASH_W-1:0] i_tx_clashes,
    input wire logic [stat_pkg::PORTS-1:0] i_tx_abandoned,
    // Resource drop pulses
    input wire logic [stat_pkg::PORTS-1:0] i_tx_drop,
    input wire logic [stat_pkg::PORTS-1:0] i_rx_drop
);
    import stat_pkg::*;

    len_type [ENTRIES-1:0] add_vec;
    logic [CNT_W:0] bank_word;
    logic trig;
    logic [9:0] taddr;
    logic fetch_port;

    // Frame classification into increments
    always_comb begin
        len_type mx;
        len_type ln;
        logic legal;
        logic good;
        logic uni;
        int b;
        mx = i_long_max ? LEN_MAX_LONG : LEN_MAX_STD;
        ln = '0;
        legal = 1'b0;
        good = 1'b0;
        uni = 1'b0;
        b = 0;
        add_vec = '0;
        for (int p = 0; p < PORTS; p++) begin
            b = p * PER_PORT;
            if (i_rx_valid[p]) begin
                ln = i_rx_len[p];
                legal = ln >= LEN_MIN && ln <= mx;
                good = legal && !i_rx_bad_crc[p] && !i_rx_bad_symbol[p];
                if (i_rx_hi_prio[p]) begin
                    add_vec[b+IX_RX_HI_OCT] = ln;
                end else begin
                    add_vec[b+IX_RX_LO_OCT] = ln;
                end
                if (ln < LEN_MIN) begin
                    add_vec[b+IX_RX_SHORT_GOOD] = len_type'(!i_rx_bad_crc[p]);
                    add_vec[b+IX_RX_SHORT_BAD] = len_type'(i_rx_bad_crc[p]
                        | i_rx_bad_symbol[p] | i_rx_odd_bits[p]);
                end
                if (ln > mx) begin
                    add_vec[b+IX_RX_LONG_GOOD] = len_type'(!i_rx_bad_crc[p]);
                    add_vec[b+IX_RX_LONG_BAD] = len_type'(i_rx_bad_crc[p]
                        | i_rx_bad_symbol[p] | i_rx_odd_bits[p]);
                end
                add_vec[b+IX_RX_BAD_SYM] =
                    len_type'(legal && i_rx_bad_symbol[p]);
                if (legal && i_rx_bad_crc[p]) begin
                    add_vec[b+IX_RX_CRC_FAIL] = len_type'(!i_rx_odd_bits[p]);
                    add_vec[b+IX_RX_MISALIGN] = len_type'(i_rx_odd_bits[p]);
                end
                add_vec[b+IX_RX_MAC_CTRL] =
                    len_type'(i_rx_mac_ctrl[p]);
                add_vec[b+IX_RX_FLOW_STOP] = len_type'(i_rx_mac_ctrl[p]
                    && i_rx_pause_fmt[p] && ln >= LEN_MIN
                    && !i_rx_bad_crc[p]);
                uni = !i_rx_bcast[p] && !i_rx_mcast[p];
                add_vec[b+IX_RX_ALL_DEST] = len_type'(good && i_rx_bcast[p]);
                add_vec[b+IX_RX_GROUP_DEST] = len_type'(good && i_rx_mcast[p]
                    && !i_rx_bcast[p] && !i_rx_mac_ctrl[p]);
                add_vec[b+IX_RX_SINGLE_DEST] = len_type'(good && uni);
                if (ln == LEN_MIN) begin
                    add_vec[b+IX_RX_BIN_MIN] = len_type'(1);
                end else if (ln > LEN_MIN && ln <= LEN_BIN_B) begin
                    add_vec[b+IX_RX_BIN_MIN+1] = len_type'(1);
                end else if (ln > LEN_BIN_B && ln <= LEN_BIN_C) begin
                    add_vec[b+IX_RX_BIN_MIN+2] = len_type'(1);
                end else if (ln > LEN_BIN_C && ln <= LEN_BIN_D) begin
                    add_vec[b+IX_RX_BIN_MIN+3] = len_type'(1);
                end else if (ln > LEN_BIN_D && ln <= LEN_BIN_E) begin
                    add_vec[b+IX_RX_BIN_MIN+4] = len_type'(1);
                end else if (ln > LEN_BIN_E && ln <= mx) begin
                    add_vec[b+IX_RX_BIN_MIN+5] = len_type'(1);
                end
            end
            if (i_tx_valid[p]) begin
                good = i_tx_ok[p];
                uni = !i_tx_bcast[p] && !i_tx_mcast[p];
                if (good && i_tx_hi_prio[p]) begin
                    add_vec[b+IX_TX_HI_OCT] = i_tx_len[p];
                end else if (good) begin
                    add_vec[b+IX_TX_LO_OCT] = i_tx_len[p];
                end
                add_vec[b+IX_TX_LATE_CLASH] =
                    len_type'(i_tx_late_clash[p]);
                add_vec[b+IX_TX_FLOW_STOP] = len_type'(good && i_tx_pause[p]);
                add_vec[b+IX_TX_ALL_DEST] = len_type'(good && i_tx_bcast[p]);
                add_vec[b+IX_TX_GROUP_DEST] =
                    len_type'(good && i_tx_mcast[p] && !i_tx_bcast[p]);
                add_vec[b+IX_TX_SINGLE_DEST] = len_type'(good && uni);
                add_vec[b+IX_TX_POSTPONED] =
                    len_type'(i_tx_postponed[p]);
                add_vec[b+IX_TX_ALL_CLASH] = len_type'(i_tx_clashes[p]);
                add_vec[b+IX_TX_ABANDONED] = len_type'(i_tx_abandoned[p]);
                add_vec[b+IX_TX_ONE_CLASH] =
                    len_type'(good && i_tx_clashes[p] == CLASH_W'(1));
                add_vec[b+IX_TX_MANY_CLASH] =
                    len_type'(good && i_tx_clashes[p] > CLASH_W'(1));
            end
        end
    end

    // Indirect fetch sequencing
    logic [7:0] ctrl_q, ctrl_d;
    logic [31:0] data_q, data_d;
    logic [7:0] rdata_q, rdata_d;
    fetch_state_type state_q, state_d;
    logic [DROPS-1:0][DROP_W-1:0] drop_q, drop_d;

    assign trig = i_reg_wr && i_reg_addr == REG_TRIG
        && ctrl_q[7:2] == SEL_COUNTERS;
    assign taddr = {ctrl_q[1:0], i_reg_wdata};
    assign fetch_port = trig && taddr < PORT_END;

    always_comb begin
        logic [9:0] di;
        di = taddr - DROP_BASE;
        ctrl_d = ctrl_q;
        data_d = data_q;
        state_d = state_q;
        drop_d = drop_q;
        rdata_d = rdata_q;
        for (int p = 0; p < PORTS; p++) begin
            drop_d[p] = drop_q[p] + DROP_W'(i_tx_drop[p]);
            drop_d[p+PORTS] = drop_q[p+PORTS] + DROP_W'(i_rx_drop[p]);
        end
        if (i_reg_wr && i_reg_addr == REG_CTRL) begin
            ctrl_d = i_reg_wdata;
        end
        unique case (state_q)
            ST_IDLE: begin
                if (fetch_port) begin
                    data_d = '0;
                    state_d = ST_FETCH;
                end else if (trig && taddr >= DROP_BASE
                        && taddr < DROP_END) begin
                    data_d = 32'(drop_q[di[2:0]]);
                end else if (trig) begin
                    data_d = '0;
                end
            end
            ST_FETCH: begin
                data_d = {bank_word[CNT_W], 1'b1,
                    bank_word[CNT_W-1:0]};
                state_d = ST_IDLE;
            end
        endcase
        if (i_reg_rd) begin
            unique case (i_reg_addr)
                REG_CTRL: rdata_d = ctrl_q;
                REG_DATA3: rdata_d = data_q[31:24];
                REG_DATA2: rdata_d = data_q[23:16];
                REG_DATA1: rdata_d = data_q[15:8];
                REG_DATA0: rdata_d = data_q[7:0];
                default: rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            ctrl_q <= CTRL_RESET;
            data_q <= '0;
            state_q <= ST_IDLE;
            drop_q <= '0;
            rdata_q <= '0;
        end else if (i_ce) begin
            ctrl_q <= ctrl_d;
            data_q <= data_d;
            state_q <= state_d;
            drop_q <= drop_d;
            rdata_q <= rdata_d;
        end
    end

    assign o_reg_rdata = rdata_q;

    // Port counter storage
    stat_bank u_bank (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .i_add(add_vec),
        .i_rd_en(fetch_port && state_q == ST_IDLE && i_ce),
        .i_rd_idx(taddr[IDX_W-1:0]),
        .o_rd_word(bank_word)
    );

    chk_fetch_valid: assert property (
        @(posedge i_mclk) disable iff (!i_nrst || !i_ce)
        fetch_port && state_q == ST_IDLE
        |=> !data_q[VALID_BIT] ##1 data_q[VALID_BIT])
        else $error("Valid flag timing wrong");

    chk_gap_zero: assert property (
        @(posedge i_mclk) disable iff (!i_nrst || !i_ce)
        trig && state_q == ST_IDLE && taddr >= PORT_END
        && taddr < DROP_BASE |=> data_q == '0)
        else $error("Unmapped address returned data");

    chk_drop_hold: assert property (
        @(posedge i_mclk) disable iff (!i_nrst || !i_ce)
        trig && taddr == DROP_BASE && !i_tx_drop[0]
        |=> drop_q[0] == $past(drop_q[0]))
        else $error("Drop counter changed by read");

    chk_drop_count: assert property (
        @(posedge i_mclk) disable iff (!i_nrst || !i_ce)
        i_rx_drop[2] |=> drop_q[5] == DROP_W'($past(drop_q[5]) + 1'b1))
        else $error("Rx drop counter did not step");

    chk_bin_min: assert property (
        @(posedge i_mclk) disable iff (!i_nrst || !i_ce)
        i_rx_valid[1] && i_rx_len[1] == LEN_MIN
        |-> add_vec[PER_PORT+IX_RX_BIN_MIN] == len_type'(1))
        else $error("Minimum bin missed");

    chk_crc_split: assert property (
        @(posedge i_mclk) disable iff (!i_nrst || !i_ce)
        i_rx_valid[0] && i_rx_bad_crc[0] && i_rx_len[0] == LEN_MIN
        |-> add_vec[IX_RX_CRC_FAIL] + add_vec[IX_RX_MISALIGN]
            == len_type'(1))
        else $error("Checksum failure not counted once");

    chk_octet_sum: assert property (
        @(posedge i_mclk) disable iff (!i_nrst || !i_ce)
        i_rx_valid[0]
        |-> len_type'(add_vec[IX_RX_LO_OCT] + add_vec[IX_RX_HI_OCT])
            == i_rx_len[0])
        else $error("Rx octets not counted");
endmodule : port_stats

/* verification/tb_port_stats.sv */
/*
 Self-checking bench for port_stats: frame summaries in, counters out.
 Assumes the byte-wide management port and a reference model kept here.
*/
`timescale 1ns/1ns
module tb_port_stats;
    import stat_pkg::*;
    logic mclk = 1'b0;
    logic nrst, ce, reg_wr, reg_rd, long_max;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [PORTS-1:0] rx_valid, rx_hi, rx_crc, rx_odd, rx_sym, rx_ctrl;
    logic [PORTS-1:0] rx_pause, rx_bc, rx_mc, tx_valid, tx_ok, tx_hi;
    logic [PORTS-1:0] tx_pause, tx_bc, tx_mc, tx_post, tx_late, tx_aband;
    logic [PORTS-1:0] tx_drop, rx_drop;
    logic [PORTS-1:0][CLASH_W-1:0] tx_clash;
    len_type [PORTS-1:0] rx_len, tx_len;
    int fail_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int e[PER_PORT];
    int lens[8] = '{127, 255, 511, 1023, 256, 512, 1024, 1536};

    port_stats i_dut (
        .i_mclk(mclk), .i_nrst(nrst), .i_ce(ce),
        .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_addr(reg_addr),
        .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata),
        .i_long_max(long_max),
        .i_rx_valid(rx_valid), .i_rx_len(rx_len), .i_rx_hi_prio(rx_hi),
        .i_rx_bad_crc(rx_crc), .i_rx_odd_bits(rx_odd),
        .i_rx_bad_symbol(rx_sym), .i_rx_mac_ctrl(rx_ctrl),
        .i_rx_pause_fmt(rx_pause), .i_rx_bcast(rx_bc), .i_rx_mcast(rx_mc),
        .i_tx_valid(tx_valid), .i_tx_len(tx_len), .i_tx_ok(tx_ok),
        .i_tx_hi_prio(tx_hi), .i_tx_pause(tx_pause), .i_tx_bcast(tx_bc),
        .i_tx_mcast(tx_mc), .i_tx_postponed(tx_post),
        .i_tx_late_clash(tx_late), .i_tx_clashes(tx_clash),
        .i_tx_abandoned(tx_aband), .i_tx_drop(tx_drop), .i_rx_drop(rx_drop)
    );

    always #10 mclk = ~mclk;

    task automatic final_report;
        $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 40000) begin
            fail_count++;
            final_report();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        samples_checked++;
        if (got !== want) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask : chk

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge mclk);
        reg_wr = 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge mclk);
        reg_rd = 1'b0;
        @(negedge mclk);
        d = reg_rdata;
    endtask : reg_read

    task automatic rd_word(output logic [31:0] w);
        repeat (2) @(negedge mclk);
        reg_read(REG_DATA3, w[31:24]);
        reg_read(REG_DATA2, w[23:16]);
        reg_read(REG_DATA1, w[15:8]);
        reg_read(REG_DATA0, w[7:0]);
    endtask : rd_word

    task automatic rd_cnt(input logic [9:0] a, output logic [31:0] w);
        reg_write(REG_CTRL, {SEL_COUNTERS, a[9:8]});
        reg_write(REG_TRIG, a[7:0]);
        rd_word(w);
    endtask : rd_cnt

    task automatic check_port(input int p);
        logic [31:0] w;
        for (int i = 0; i < PER_PORT; i++) begin
            rd_cnt(10'(p * PER_PORT + i), w);
            chk(w, {2'b01, 30'(e[i])});
            e[i] = 0;
        end
    endtask : check_port

    task automatic rx_case(input int p, input int len, input logic [7:0] f,
                           input logic lm);
        int mx;
        logic hi, crc, odd, sym, ctl, pse, bc, mc, legal;
        {hi, crc, odd, sym, ctl, pse, bc, mc} = f;
        mx = lm ? 1536 : 1522;
        legal = len >= 64 && len <= mx;
        e[hi ? IX_RX_HI_OCT : IX_RX_LO_OCT] += len;
        if (len < 64) e[crc ? IX_RX_SHORT_BAD : IX_RX_SHORT_GOOD]++;
        if (len > mx) e[crc ? IX_RX_LONG_BAD : IX_RX_LONG_GOOD]++;
        if (legal && sym) e[IX_RX_BAD_SYM]++;
        if (legal && crc) e[odd ? IX_RX_MISALIGN : IX_RX_CRC_FAIL]++;
        if (ctl) e[IX_RX_MAC_CTRL]++;
        if (ctl && pse && len >= 64 && !crc) e[IX_RX_FLOW_STOP]++;
        if (legal && !crc && !sym) begin
            if (bc) e[IX_RX_ALL_DEST]++;
            else if (mc) begin
                if (!ctl) e[IX_RX_GROUP_DEST]++;
            end else e[IX_RX_SINGLE_DEST]++;
        end
        if (legal) e[IX_RX_BIN_MIN + (len == 64 ? 0 : len < 128 ? 1 :
            len < 256 ? 2 : len < 512 ? 3 : len < 1024 ? 4 : 5)]++;
        @(negedge mclk);
        long_max = lm;
        rx_valid[p] = 1'b1;
        rx_len[p] = LEN_W'(len);
        {rx_hi[p], rx_crc[p], rx_odd[p], rx_sym[p]} = {hi, crc, odd, sym};
        {rx_ctrl[p], rx_pause[p], rx_bc[p], rx_mc[p]} = {ctl, pse, bc, mc};
        @(negedge mclk);
        rx_valid = '0;
        check_port(p);
    endtask : rx_case

    task automatic tx_case(input int p, input int len, input logic [7:0] f,
                           input int cl);
        logic ok, hi, pse, bc, mc, post, late, ab;
        {ok, hi, pse, bc, mc, post, late, ab} = f;
        if (ok) begin
            e[hi ? IX_TX_HI_OCT : IX_TX_LO_OCT] += len;
            if (pse) e[IX_TX_FLOW_STOP]++;
            if (bc) e[IX_TX_ALL_DEST]++;
            else if (mc) e[IX_TX_GROUP_DEST]++;
            else e[IX_TX_SINGLE_DEST]++;
            if (cl == 1) e[IX_TX_ONE_CLASH]++;
            else if (cl > 1) e[IX_TX_MANY_CLASH]++;
        end
        if (late) e[IX_TX_LATE_CLASH]++;
        if (post) e[IX_TX_POSTPONED]++;
        if (ab) e[IX_TX_ABANDONED]++;
        e[IX_TX_ALL_CLASH] += cl;
        @(negedge mclk);
        tx_valid[p] = 1'b1;
        tx_len[p] = LEN_W'(len);
        tx_clash[p] = CLASH_W'(cl);
        {tx_ok[p], tx_hi[p], tx_pause[p], tx_bc[p]} = {ok, hi, pse, bc};
        {tx_mc[p], tx_post[p], tx_late[p], tx_aband[p]} = {mc, post, late, ab};
        @(negedge mclk);
        tx_valid = '0;
        check_port(p);
    endtask : tx_case

    initial begin
        logic [31:0] w;
        logic [7:0] b;
        {nrst, ce, reg_wr, reg_rd, long_max} = 5'b01000;
        {reg_addr, reg_wdata} = '0;
        {rx_valid, rx_hi, rx_crc, rx_odd, rx_sym, rx_ctrl} = '0;
        {rx_pause, rx_bc, rx_mc, tx_valid, tx_ok, tx_hi} = '0;
        {tx_pause, tx_bc, tx_mc, tx_post, tx_late, tx_aband} = '0;
        {tx_drop, rx_drop, tx_clash, rx_len, tx_len} = '0;
        foreach (e[i]) e[i] = 0;
        repeat (3) @(negedge mclk);
        nrst = 1'b1;
        for (int p = 0; p < PORTS; p++) check_port(p);
        reg_read(8'h10, b);
        chk({24'h0, b}, 32'h0000_0000);
        rx_case(0, 64, 8'b0000_0000, 0);
        rx_case(1, 65, 8'b1000_0010, 0);
        rx_case(2, 63, 8'b0000_0000, 0);
        rx_case(0, 63, 8'b0100_0000, 0);
        rx_case(1, 1523, 8'b0000_0000, 0);
        rx_case(1, 1523, 8'b0000_0000, 1);
        rx_case(2, 1537, 8'b0100_0000, 1);
        rx_case(2, 1523, 8'b0110_0000, 0);
        rx_case(0, 100, 8'b0001_0000, 0);
        rx_case(1, 1522, 8'b0100_0000, 0);
        rx_case(2, 200, 8'b0110_0000, 0);
        rx_case(0, 64, 8'b0000_1101, 0);
        rx_case(1, 64, 8'b0000_1001, 0);
        rx_case(2, 64, 8'b0100_1101, 0);
        rx_case(0, 128, 8'b0000_0001, 0);
        for (int k = 0; k < 8; k++) begin
            rx_case(k % 3, lens[k], 8'h00, k == 7);
        end
        tx_case(0, 100, 8'b1000_0000, 0);
        tx_case(1, 1500, 8'b1101_0000, 0);
        tx_case(2, 64, 8'b1010_1000, 0);
        tx_case(0, 80, 8'b1000_0100, 0);
        tx_case(1, 90, 8'b1000_0010, 3);
        tx_case(2, 70, 8'b1000_0000, 1);
        tx_case(0, 70, 8'b0000_0001, 15);
        for (int k = 0; k < 7; k++) begin
            @(negedge mclk);
            for (int p = 0; p < PORTS; p++) begin
                tx_drop[p] = k < p + 1;
                rx_drop[p] = k < p + 4;
            end
        end
        @(negedge mclk);
        {tx_drop, rx_drop} = '0;
        for (int r = 0; r < 2; r++) begin
            for (int p = 0; p < PORTS; p++) begin
                rd_cnt(DROP_BASE + 10'(p), w);
                chk(w, 32'(p + 1));
                rd_cnt(DROP_BASE + 10'(p + 3), w);
                chk(w, 32'(p + 4));
            end
        end
        reg_write(REG_CTRL, 8'h18);
        reg_write(REG_TRIG, 8'h00);
        rd_word(w);
        chk(w, 32'h0000_0006);
        rd_cnt(PORT_END, w);
        chk(w, 32'h0000_0000);
        rd_cnt(DROP_END, w);
        chk(w, 32'h0000_0000);
        reg_read(REG_CTRL, b);
        chk({24'h0, b}, 32'h0000_001D);
        // Drop pulses while the enable is low must not count
        @(negedge mclk);
        {ce, tx_drop[0]} = 2'b01;
        repeat (3) @(negedge mclk);
        {ce, tx_drop[0]} = 2'b10;
        rd_cnt(DROP_BASE, w);
        chk(w, 32'h0000_0001);
        // Second reset in mid-run
        @(negedge mclk);
        nrst = 1'b0;
        repeat (2) @(negedge mclk);
        nrst = 1'b1;
        reg_read(REG_CTRL, b);
        chk({24'h0, b}, 32'h0000_0000);
        rd_cnt(DROP_BASE + 10'h005, w);
        chk(w, 32'h0000_0000);
        final_report();
    end
endmodule : tb_port_stats
